/* File: design/meter_scaling_defs.vh */
`ifndef METER_SCALING_DEFS_VH
`define METER_SCALING_DEFS_VH

// gain format: factor times 2^14, 0x4000 is unity
`define GAIN_FRAC_BITS      14
`define GAIN_UNITY          16'h4000

// raw result registers, phase n at base + n * stride
`define ADDR_VRMS_RAW_A     12'h1C8
`define ADDR_IRMS_RAW_A     12'h1CC
`define ADDR_ENERGY_RAW_A   12'h1D0
`define ADDR_POWER_RAW_A    12'h1D4
`define ADDR_RAW_STRIDE     12'h040

// per-phase gain and phase angle registers, phase n at base + n * stride
`define ADDR_VGAIN_A        12'h300
`define ADDR_IGAIN_A        12'h301
`define ADDR_PGAIN_A        12'h302
`define ADDR_PA0_A          12'h303
`define ADDR_PA1_A          12'h304
`define ADDR_PA2_A          12'h305
`define ADDR_GAIN_STRIDE    12'h010

// conversion coefficients
`define ADDR_VOLTAGE_CONVERSION_COEFFICIENT        12'h010
`define ADDR_CURR_CC        12'h011
`define ADDR_POWER_CONVERSION_COEFFICIENT         12'h012
`define ADDR_ENERGY_CONVERSION_COEFFICIENT         12'h013
`define CC_RESET            16'h0000

// phase angle current-level thresholds
`define ADDR_I1THR          12'h020
`define ADDR_I2THR          12'h021

// calibration pulse output
`define ADDR_PULSE_SEL      12'h030
`define ADDR_PULSE_THR      12'h031
`define PULSE_SEL_OFF       4'h0
`define PULSE_THR_RESET     32'h0000_0000

// virtual registers, phase A first, phases consecutive
`define ADDR_VIRT_VOLT_A    12'h821
`define ADDR_VIRT_CURR_A    12'h831
`define ADDR_VIRT_PWR_A     12'h841
`define ADDR_VIRT_ENR_A     12'h851

// current level compared with the thresholds: rms bits 23:8
`define LEVEL_MSB           23
`define LEVEL_LSB           8

`endif

/* File: design/gain_scale.v */
`timescale 1ns/1ps
// registered signed value times unsigned gain, scaled down by the gain fraction
module gain_scale #(
    parameter DW   = 32,
    parameter GW   = 16,
    parameter FRAC = 14
) (
    input  wire          ref_clk_i,
    input  wire          sys_rst_i,
    input  wire          in_valid_i,
    input  wire [DW-1:0] data_i,
    input  wire [GW-1:0] gain_i,
    output reg           out_valid_o,
    output reg  [DW-1:0] data_o
);
    wire signed [DW+GW:0] product;
    wire signed [DW+GW:0] shifted;

    assign product = $signed(data_i) * $signed({1'b0, gain_i});
    assign shifted = product >>> FRAC;

    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            out_valid_o <= 1'b0;
            data_o      <= {DW{1'b0}};
        end else begin
            out_valid_o <= in_valid_i;
            if (in_valid_i) begin
                data_o <= shifted[DW-1:0];
            end
        end
    end
endmodule // gain_scale

/* File: design/meter_scaling.v */
// Summary of operation
// - virtual register read returns raw result times its class conversion coefficient
// - scaled phase A current read at 0x831 from raw current and coefficient
// - raw phase A current rms readable as 32-bit word at 0x1CC
// - scaled results carry 16 fractional bits; host drops low 16 bits
// - gain value 0x4000 means unity gain, removing earlier correction
// - gain is factor times 2^14; host keeps the top bit zero
// - rms results reflect a new gain within two to three seconds
// - raw voltage lsb is full-scale voltage over 2^24
// - per-phase voltage, current and power gains; power and energy use all three
// - a pulse output can be assigned to the quantity under calibration
// - phase angle offset adjustable per phase at up to three current points
`timescale 1ns/1ps
`include "meter_scaling_defs.vh"
module meter_scaling #(
    parameter PHASES = 3,
    parameter DW     = 32,
    parameter GW     = 16,
    parameter ACCW   = 40
) (
    input  wire                 ref_clk_i,
    input  wire                 sys_rst_i,
    input  wire [11:0]          reg_addr_i,
    input  wire                 reg_wr_i,
    input  wire                 reg_rd_i,
    input  wire [31:0]          reg_wdata_i,
    output reg  [31:0]          reg_rdata_o,
    output reg                  reg_rvalid_o,
    input  wire                 meas_valid_i,
    input  wire [PHASES*DW-1:0] volt_raw_i,
    input  wire [PHASES*DW-1:0] curr_raw_i,
    input  wire [PHASES*DW-1:0] pwr_raw_i,
    output reg                  pulse_o,
    output reg  [PHASES*GW-1:0] phase_offset_o
);
    reg  [DW-1:0]   vrms_reg   [0:PHASES-1];
    reg  [DW-1:0]   irms_reg   [0:PHASES-1];
    reg  [DW-1:0]   power_reg  [0:PHASES-1];
    reg  [DW-1:0]   energy_reg [0:PHASES-1];
    reg  [GW-1:0]   vgain_reg  [0:PHASES-1];
    reg  [GW-1:0]   igain_reg  [0:PHASES-1];
    reg  [GW-1:0]   pgain_reg  [0:PHASES-1];
    reg  [GW-1:0]   pa0_reg    [0:PHASES-1];
    reg  [GW-1:0]   pa1_reg    [0:PHASES-1];
    reg  [GW-1:0]   pa2_reg    [0:PHASES-1];
    reg  [GW-1:0]   voltage_conversion_coefficient_reg;
    reg  [GW-1:0]   curr_cc_reg;
    reg  [GW-1:0]   power_conversion_coefficient_reg;
    reg  [GW-1:0]   energy_conversion_coefficient_reg;
    reg  [GW-1:0]   i1thr_reg;
    reg  [GW-1:0]   i2thr_reg;
    reg  [3:0]      pulse_sel_reg;
    reg  [DW-1:0]   pulse_thr_reg;
    reg  [ACCW-1:0] pulse_acc_reg;
    reg  [ACCW-1:0] pulse_acc_next;
    reg  [DW-1:0]   pulse_mag;
    reg  [31:0]     rdata_next;
    reg  [DW+GW-1:0] virt_prod;
    reg  [DW-1:0]   virt_raw;
    reg  [GW-1:0]   virt_cc;
    reg             virt_hit;
    wire [DW-1:0]   v_corr   [0:PHASES-1];
    wire [DW-1:0]   i_corr   [0:PHASES-1];
    wire [DW-1:0]   p_stage1 [0:PHASES-1];
    wire [DW-1:0]   p_stage2 [0:PHASES-1];
    wire [DW-1:0]   p_corr   [0:PHASES-1];
    wire            v_valid  [0:PHASES-1];
    wire            p1_valid [0:PHASES-1];
    wire            p2_valid [0:PHASES-1];
    wire            p_valid  [0:PHASES-1];
    integer         k, kw, kr, kp, ko;

    // power is scaled by voltage, current and power gain in turn
    genvar g;
    generate
        for (g = 0; g < PHASES; g = g + 1) begin : phase
            gain_scale #(.DW(DW), .GW(GW), .FRAC(`GAIN_FRAC_BITS)) u_vscale (
                .ref_clk_i   (ref_clk_i),
                .sys_rst_i   (sys_rst_i),
                .in_valid_i  (meas_valid_i),
                .data_i      (volt_raw_i[g*DW +: DW]),
                .gain_i      (vgain_reg[g]),
                .out_valid_o (v_valid[g]),
                .data_o      (v_corr[g])
            );
            gain_scale #(.DW(DW), .GW(GW), .FRAC(`GAIN_FRAC_BITS)) u_iscale (
                .ref_clk_i   (ref_clk_i),
                .sys_rst_i   (sys_rst_i),
                .in_valid_i  (meas_valid_i),
                .data_i      (curr_raw_i[g*DW +: DW]),
                .gain_i      (igain_reg[g]),
                .out_valid_o (),
                .data_o      (i_corr[g])
            );
            gain_scale #(.DW(DW), .GW(GW), .FRAC(`GAIN_FRAC_BITS)) u_pscale_v (
                .ref_clk_i   (ref_clk_i),
                .sys_rst_i   (sys_rst_i),
                .in_valid_i  (meas_valid_i),
                .data_i      (pwr_raw_i[g*DW +: DW]),
                .gain_i      (vgain_reg[g]),
                .out_valid_o (p1_valid[g]),
                .data_o      (p_stage1[g])
            );
            gain_scale #(.DW(DW), .GW(GW), .FRAC(`GAIN_FRAC_BITS)) u_pscale_i (
                .ref_clk_i   (ref_clk_i),
                .sys_rst_i   (sys_rst_i),
                .in_valid_i  (p1_valid[g]),
                .data_i      (p_stage1[g]),
                .gain_i      (igain_reg[g]),
                .out_valid_o (p2_valid[g]),
                .data_o      (p_stage2[g])
            );
            gain_scale #(.DW(DW), .GW(GW), .FRAC(`GAIN_FRAC_BITS)) u_pscale_p (
                .ref_clk_i   (ref_clk_i),
                .sys_rst_i   (sys_rst_i),
                .in_valid_i  (p2_valid[g]),
                .data_i      (p_stage2[g]),
                .gain_i      (pgain_reg[g]),
                .out_valid_o (p_valid[g]),
                .data_o      (p_corr[g])
            );
        end
    endgenerate

    // result registers follow each measurement set, so a new gain shows one set later
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            for (k = 0; k < PHASES; k = k + 1) begin
                vrms_reg[k]   <= {DW{1'b0}};
                irms_reg[k]   <= {DW{1'b0}};
                power_reg[k]  <= {DW{1'b0}};
                energy_reg[k] <= {DW{1'b0}};
            end
        end else begin
            for (k = 0; k < PHASES; k = k + 1) begin
                if (v_valid[k]) begin
                    vrms_reg[k] <= v_corr[k];
                    irms_reg[k] <= i_corr[k];
                end
                if (p_valid[k]) begin
                    power_reg[k]  <= p_corr[k];
                    energy_reg[k] <= energy_reg[k] + p_corr[k];
                end
            end
        end
    end

    // register writes; gains reset to unity, constants reloaded by the host
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            for (kw = 0; kw < PHASES; kw = kw + 1) begin
                vgain_reg[kw] <= `GAIN_UNITY;
                igain_reg[kw] <= `GAIN_UNITY;
                pgain_reg[kw] <= `GAIN_UNITY;
                pa0_reg[kw]   <= {GW{1'b0}};
                pa1_reg[kw]   <= {GW{1'b0}};
                pa2_reg[kw]   <= {GW{1'b0}};
            end
            voltage_conversion_coefficient_reg   <= `CC_RESET;
            curr_cc_reg   <= `CC_RESET;
            power_conversion_coefficient_reg    <= `CC_RESET;
            energy_conversion_coefficient_reg    <= `CC_RESET;
            i1thr_reg     <= {GW{1'b0}};
            i2thr_reg     <= {GW{1'b0}};
            pulse_sel_reg <= `PULSE_SEL_OFF;
            pulse_thr_reg <= `PULSE_THR_RESET;
        end else if (reg_wr_i) begin
            for (kw = 0; kw < PHASES; kw = kw + 1) begin
                if (reg_addr_i == `ADDR_VGAIN_A + kw[11:0] * `ADDR_GAIN_STRIDE)
                    vgain_reg[kw] <= reg_wdata_i[GW-1:0];
                if (reg_addr_i == `ADDR_IGAIN_A + kw[11:0] * `ADDR_GAIN_STRIDE)
                    igain_reg[kw] <= reg_wdata_i[GW-1:0];
                if (reg_addr_i == `ADDR_PGAIN_A + kw[11:0] * `ADDR_GAIN_STRIDE)
                    pgain_reg[kw] <= reg_wdata_i[GW-1:0];
                if (reg_addr_i == `ADDR_PA0_A + kw[11:0] * `ADDR_GAIN_STRIDE)
                    pa0_reg[kw] <= reg_wdata_i[GW-1:0];
                if (reg_addr_i == `ADDR_PA1_A + kw[11:0] * `ADDR_GAIN_STRIDE)
                    pa1_reg[kw] <= reg_wdata_i[GW-1:0];
                if (reg_addr_i == `ADDR_PA2_A + kw[11:0] * `ADDR_GAIN_STRIDE)
                    pa2_reg[kw] <= reg_wdata_i[GW-1:0];
            end
            case (reg_addr_i)
                `ADDR_VOLTAGE_CONVERSION_COEFFICIENT:   voltage_conversion_coefficient_reg   <= reg_wdata_i[GW-1:0];
                `ADDR_CURR_CC:   curr_cc_reg   <= reg_wdata_i[GW-1:0];
                `ADDR_POWER_CONVERSION_COEFFICIENT:    power_conversion_coefficient_reg    <= reg_wdata_i[GW-1:0];
                `ADDR_ENERGY_CONVERSION_COEFFICIENT:    energy_conversion_coefficient_reg    <= reg_wdata_i[GW-1:0];
                `ADDR_I1THR:     i1thr_reg     <= reg_wdata_i[GW-1:0];
                `ADDR_I2THR:     i2thr_reg     <= reg_wdata_i[GW-1:0];
                `ADDR_PULSE_SEL: pulse_sel_reg <= reg_wdata_i[3:0];
                `ADDR_PULSE_THR: pulse_thr_reg <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // read mux; virtual reads only multiply, nothing is written back
    always @* begin
        rdata_next = 32'h0000_0000;
        virt_hit   = 1'b0;
        virt_raw   = {DW{1'b0}};
        virt_cc    = {GW{1'b0}};
        for (kr = 0; kr < PHASES; kr = kr + 1) begin
            if (reg_addr_i == `ADDR_VRMS_RAW_A + kr[11:0] * `ADDR_RAW_STRIDE)
                rdata_next = vrms_reg[kr];
            if (reg_addr_i == `ADDR_IRMS_RAW_A + kr[11:0] * `ADDR_RAW_STRIDE)
                rdata_next = irms_reg[kr];
            if (reg_addr_i == `ADDR_ENERGY_RAW_A + kr[11:0] * `ADDR_RAW_STRIDE)
                rdata_next = energy_reg[kr];
            if (reg_addr_i == `ADDR_POWER_RAW_A + kr[11:0] * `ADDR_RAW_STRIDE)
                rdata_next = power_reg[kr];
            if (reg_addr_i == `ADDR_VGAIN_A + kr[11:0] * `ADDR_GAIN_STRIDE)
                rdata_next = {16'h0000, vgain_reg[kr]};
            if (reg_addr_i == `ADDR_IGAIN_A + kr[11:0] * `ADDR_GAIN_STRIDE)
                rdata_next = {16'h0000, igain_reg[kr]};
            if (reg_addr_i == `ADDR_PGAIN_A + kr[11:0] * `ADDR_GAIN_STRIDE)
                rdata_next = {16'h0000, pgain_reg[kr]};
            if (reg_addr_i == `ADDR_PA0_A + kr[11:0] * `ADDR_GAIN_STRIDE)
                rdata_next = {16'h0000, pa0_reg[kr]};
            if (reg_addr_i == `ADDR_PA1_A + kr[11:0] * `ADDR_GAIN_STRIDE)
                rdata_next = {16'h0000, pa1_reg[kr]};
            if (reg_addr_i == `ADDR_PA2_A + kr[11:0] * `ADDR_GAIN_STRIDE)
                rdata_next = {16'h0000, pa2_reg[kr]};
            if (reg_addr_i == `ADDR_VIRT_VOLT_A + kr[11:0]) begin
                virt_hit = 1'b1;
                virt_raw = vrms_reg[kr];
                virt_cc  = voltage_conversion_coefficient_reg;
            end
            if (reg_addr_i == `ADDR_VIRT_CURR_A + kr[11:0]) begin
                virt_hit = 1'b1;
                virt_raw = irms_reg[kr];
                virt_cc  = curr_cc_reg;
            end
            if (reg_addr_i == `ADDR_VIRT_PWR_A + kr[11:0]) begin
                virt_hit = 1'b1;
                virt_raw = power_reg[kr];
                virt_cc  = power_conversion_coefficient_reg;
            end
            if (reg_addr_i == `ADDR_VIRT_ENR_A + kr[11:0]) begin
                virt_hit = 1'b1;
                virt_raw = energy_reg[kr];
                virt_cc  = energy_conversion_coefficient_reg;
            end
        end
        case (reg_addr_i)
            `ADDR_VOLTAGE_CONVERSION_COEFFICIENT:   rdata_next = {16'h0000, voltage_conversion_coefficient_reg};
            `ADDR_CURR_CC:   rdata_next = {16'h0000, curr_cc_reg};
            `ADDR_POWER_CONVERSION_COEFFICIENT:    rdata_next = {16'h0000, power_conversion_coefficient_reg};
            `ADDR_ENERGY_CONVERSION_COEFFICIENT:    rdata_next = {16'h0000, energy_conversion_coefficient_reg};
            `ADDR_I1THR:     rdata_next = {16'h0000, i1thr_reg};
            `ADDR_I2THR:     rdata_next = {16'h0000, i2thr_reg};
            `ADDR_PULSE_SEL: rdata_next = {28'h000_0000, pulse_sel_reg};
            `ADDR_PULSE_THR: rdata_next = pulse_thr_reg;
            default: begin
            end
        endcase
        // low word of the product keeps 16 fractional bits of the host unit
        virt_prod = virt_raw * virt_cc;
        if (virt_hit)
            rdata_next = virt_prod[31:0];
    end

    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o  <= 32'h0000_0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
                reg_rdata_o <= rdata_next;
        end
    end

    // pulse source: sel[3:2] class (1 volt, 2 curr, 3 power), sel[1:0] phase
    always @* begin
        pulse_mag = {DW{1'b0}};
        for (kp = 0; kp < PHASES; kp = kp + 1) begin
            if (pulse_sel_reg[1:0] == kp[1:0]) begin
                // power taken from the stage output, the same set that energy adds now
                case (pulse_sel_reg[3:2])
                    2'b01:   pulse_mag = vrms_reg[kp];
                    2'b10:   pulse_mag = irms_reg[kp];
                    2'b11:   pulse_mag = p_corr[kp][DW-1] ? -p_corr[kp] : p_corr[kp];
                    default: pulse_mag = {DW{1'b0}};
                endcase
            end
        end
        pulse_acc_next = pulse_acc_reg + {{(ACCW-DW){1'b0}}, pulse_mag};
    end

    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pulse_acc_reg <= {ACCW{1'b0}};
            pulse_o       <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            if (pulse_sel_reg[3:2] == 2'b00 || pulse_thr_reg == {DW{1'b0}}) begin
                pulse_acc_reg <= {ACCW{1'b0}};
            end else if (p_valid[0]) begin
                if (pulse_acc_next >= {{(ACCW-DW){1'b0}}, pulse_thr_reg}) begin
                    pulse_acc_reg <= pulse_acc_next - {{(ACCW-DW){1'b0}}, pulse_thr_reg};
                    pulse_o       <= 1'b1;
                end else begin
                    pulse_acc_reg <= pulse_acc_next;
                end
            end
        end
    end

    // phase angle offset chosen by current level against two thresholds
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            phase_offset_o <= {(PHASES*GW){1'b0}};
        end else begin
            for (ko = 0; ko < PHASES; ko = ko + 1) begin
                if (i2thr_reg != {GW{1'b0}} && irms_reg[ko][`LEVEL_MSB:`LEVEL_LSB] >= i2thr_reg)
                    phase_offset_o[ko*GW +: GW] <= pa2_reg[ko];
                else if (i1thr_reg != {GW{1'b0}}
                         && irms_reg[ko][`LEVEL_MSB:`LEVEL_LSB] >= i1thr_reg)
                    phase_offset_o[ko*GW +: GW] <= pa1_reg[ko];
                else
                    phase_offset_o[ko*GW +: GW] <= pa0_reg[ko];
            end
        end
    end
endmodule // meter_scaling

/* File: bench/meter_scaling_assertions.sv */
`timescale 1ns/1ps
module meter_scaling_checker #(
    parameter PHASES = 3,
    parameter DW     = 32,
    parameter GW     = 16
) (
    input wire                 ref_clk_i,
    input wire                 sys_rst_i,
    input wire [11:0]          reg_addr_i,
    input wire                 reg_wr_i,
    input wire                 reg_rd_i,
    input wire [31:0]          reg_wdata_i,
    input wire [31:0]          reg_rdata_o,
    input wire                 reg_rvalid_o,
    input wire                 meas_valid_i,
    input wire                 pulse_o,
    input wire [PHASES*GW-1:0] phase_offset_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_gain_wr;
        reg_wr_i && reg_addr_i == 12'h301;
    endsequence
    sequence s_gain_rd;
        reg_rd_i && !reg_wr_i && reg_addr_i == 12'h301;
    endsequence
    sequence s_virt_rd;
        reg_rd_i && !reg_wr_i && !meas_valid_i && reg_addr_i == 12'h831;
    endsequence
    rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered one cycle later");
    rvalid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read valid without a read");
    rdata_hold_a: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (reg_rd_i && reg_addr_i == 12'h7FF
        |=> reg_rvalid_o && reg_rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
    gain_readback_a: assert property (s_gain_wr ##1 !reg_wr_i ##1 s_gain_rd
        |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 32'h0000_FFFF)) else $error("gain readback");
    virt_stable_a: assert property (!reg_wr_i && !meas_valid_i ##1 s_virt_rd
        ##1 (!reg_wr_i && !meas_valid_i) ##1 s_virt_rd |=> reg_rdata_o == $past(reg_rdata_o, 2))
        else $error("virtual read not repeatable");
    pulse_single_a: assert property (pulse_o |=> !pulse_o)
        else $error("pulse longer than one cycle");
    pulse_cause_a: assert property (pulse_o
        |-> $past(meas_valid_i, 4) || $past(meas_valid_i, 5)) else $error("pulse without strobe");
    offset_cause_a: assert property ($changed(phase_offset_o) |-> $past(reg_wr_i, 2)
        || $past(meas_valid_i, 2) || $past(meas_valid_i, 3)) else $error("offset moved alone");
endmodule // meter_scaling_checker

bind meter_scaling meter_scaling_checker #(.PHASES(PHASES), .DW(DW), .GW(GW)) i_chk (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .meas_valid_i(meas_valid_i),
    .pulse_o(pulse_o), .phase_offset_o(phase_offset_o)
);

/* File: bench/host_model.sv */
`timescale 1ns/1ps
module host_model (
    input  wire        ref_clk_i,
    input  wire [31:0] rdata_i,
    input  wire        rvalid_i,
    output reg  [11:0] addr_o,
    output reg         wr_o,
    output reg         rd_o,
    output reg  [31:0] wdata_o
);
    initial begin
        addr_o = 12'h000;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 32'h0000_0000;
    end
    task write(input [11:0] a, input [31:0] d);
        begin
            @(posedge ref_clk_i) #1;
            addr_o = a;
            wdata_o = d;
            wr_o = 1'b1;
            @(posedge ref_clk_i) #1;
            wr_o = 1'b0;
        end
    endtask
    task read(input [11:0] a, output [31:0] d, output ok);
        integer n;
        begin
            @(posedge ref_clk_i) #1;
            addr_o = a;
            rd_o = 1'b1;
            @(posedge ref_clk_i) #1;
            rd_o = 1'b0;
            for (n = 0; n < 4 && rvalid_i !== 1'b1; n = n + 1) @(posedge ref_clk_i) #1;
            ok = (rvalid_i === 1'b1);
            d = rdata_i;
        end
    endtask
    // applied over measured in gain format, rounded to nearest
    function [15:0] cal_gain(input [31:0] applied, input [31:0] measured);
        reg [63:0] q;
        begin
            q = ({32'h0000_0000, applied} * 64'h0000_0000_0000_4000 + measured / 2) / measured;
            if (q >= 64'h0000_0000_0000_8000) q = 64'h0000_0000_0000_4000;
            cal_gain = q[15:0];
        end
    endfunction
endmodule // host_model

/* File: bench/meter_scaling_and_gain_calibration_bench.sv */
`timescale 1ns/1ps
module meter_scaling_and_gain_calibration_bench;
    reg         ref_clk_i;
    reg         sys_rst_i;
    reg         meas_valid_i;
    reg  [95:0] volt_raw, curr_raw, pwr_raw;
    wire [11:0] addr;
    wire        wr, rd, rvalid, pulse;
    wire [31:0] wdata, rdata;
    wire [47:0] offs;
    integer     n_fail, num_checks, npulse, k;
    reg  [31:0] d, vexp, iexp, pexp;
    reg  [31:0] xr [0:3];
    reg         ok;

    meter_scaling i_dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .meas_valid_i(meas_valid_i), .volt_raw_i(volt_raw), .curr_raw_i(curr_raw),
        .pwr_raw_i(pwr_raw), .pulse_o(pulse), .phase_offset_o(offs)
    );
    host_model i_host (
        .ref_clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
        .wr_o(wr), .rd_o(rd), .wdata_o(wdata)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) if (pulse === 1'b1) npulse = npulse + 1;

    function [31:0] gmul(input [31:0] r, input [15:0] g);
        reg signed [63:0] t;
        begin
            t = $signed(r) * $signed({1'b0, g});
            gmul = t[45:14];
        end
    endfunction
    task conclude;
        begin
            $display("checks=%0d fails=%0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task rchk(input [11:0] a, input [31:0] exp);
        begin
            i_host.read(a, d, ok);
            if (ok !== 1'b1) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t read timeout addr=%h", $time, a);
                conclude;
            end else chk(d, exp);
        end
    endtask
    // phase A set of one measurement; settle time covers the power stages
    task meas(input [31:0] v, input [31:0] i, input [31:0] p);
        begin
            @(posedge ref_clk_i) #1;
            volt_raw[31:0] = v;
            curr_raw[31:0] = i;
            pwr_raw[31:0] = p;
            meas_valid_i = 1'b1;
            @(posedge ref_clk_i) #1;
            meas_valid_i = 1'b0;
            repeat (6) @(posedge ref_clk_i);
        end
    endtask

    initial begin
        sys_rst_i = 1'b1;
        meas_valid_i = 1'b0;
        volt_raw = 96'h0011_2233_0044_5566_0000_0000;
        curr_raw = 96'h0001_2000_0003_4000_0000_0000;
        pwr_raw = 96'h0000_1000_0000_2000_0000_0000;
        n_fail = 0;
        num_checks = 0;
        npulse = 0;
        repeat (5) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        rchk(12'h301, 32'h0000_4000);
        rchk(12'h011, 32'h0000_0000);
        rchk(12'h7FF, 32'h0000_0000);
        i_host.write(12'h011, 32'h0000_0190);
        meas(32'h0070_8029, 32'h0076_54AF, 32'h0000_0000);
        rchk(12'h1CC, 32'h0076_54AF);
        rchk(12'h831, 32'hB8E4_5170);
        chk({16'h0000, d[31:16]}, 32'h0000_B8E4);
        rchk(12'h831, 32'hB8E4_5170);
        i_host.write(12'h1CC, 32'h0000_1234);
        rchk(12'h1CC, 32'h0076_54AF);
        rchk(12'h011, 32'h0000_0190);
        $display("test virtual_current done");
        d = {16'h0000, i_host.cal_gain(32'h006E_1679, 32'h0070_8029)};
        chk(d, 32'h0000_3EA1);
        i_host.write(12'h300, d);
        i_host.write(12'h301, 32'hABCD_430E);
        rchk(12'h301, 32'h0000_430E);
        i_host.write(12'h302, 32'h0000_2000);
        vexp = gmul(32'h0070_8029, 16'h3EA1);
        iexp = gmul(32'h0017_DC85, 16'h430E);
        pexp = gmul(gmul(gmul(32'h0010_0000, 16'h3EA1), 16'h430E), 16'h2000);
        i_host.write(12'h031, pexp);
        i_host.write(12'h030, 32'h0000_000C);
        meas(32'h0070_8029, 32'h0017_DC85, 32'h0010_0000);
        meas(32'h0070_8029, 32'h0017_DC85, 32'h0010_0000);
        rchk(12'h1C8, vexp);
        rchk(12'h1CC, iexp);
        rchk(12'h1D4, pexp);
        rchk(12'h1D0, pexp + pexp);
        chk(npulse[31:0], 32'h0000_0002);
        i_host.write(12'h030, 32'h0000_0000);
        xr[0] = vexp;
        xr[1] = iexp;
        xr[2] = pexp;
        xr[3] = pexp + pexp;
        for (k = 0; k < 4; k = k + 1) begin
            i_host.write(12'h010 + k[11:0], k + 2);
            rchk(12'h821 + 12'h010 * k[11:0], xr[k] * (k + 2));
        end
        $display("test calibration done");
        i_host.write(12'h301, 32'h0000_4000);
        i_host.write(12'h031, 32'h0017_DC85);
        i_host.write(12'h030, 32'h0000_0008);
        meas(32'h0070_8029, 32'h0017_DC85, 32'h0000_0000);
        rchk(12'h1CC, 32'h0017_DC85);
        chk(npulse[31:0], 32'h0000_0003);
        $display("test unity_gain done");
        i_host.write(12'h303, 32'h0000_1111);
        i_host.write(12'h304, 32'h0000_2222);
        i_host.write(12'h305, 32'h0000_3333);
        i_host.write(12'h020, 32'h0000_0100);
        i_host.write(12'h021, 32'h0000_1000);
        i_host.write(12'h031, vexp);
        i_host.write(12'h030, 32'h0000_0004);
        for (k = 0; k < 3; k = k + 1) begin
            meas(32'h0070_8029, 32'h0000_2000 << (4 * k), 32'h0000_0000);
            chk({16'h0000, offs[15:0]}, 32'h0000_1111 * (k + 1));
        end
        chk(npulse[31:0], 32'h0000_0006);
        $display("test phase_offset done");
        conclude;
    end
endmodule // meter_scaling_and_gain_calibration_bench
